// ===== pkg/drc_pkg.sv
// Purpose: constants and carrier types for the dynamic ram board controller
// Assumes: 50 MHz clock, 20 ns period
// Notes: timing counts are derived from printed times
package drc_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int CE_MIN_PS = 330000;
  localparam int SB_MIN_PS = 120000;
  localparam int REF_PERIOD_NS = 62400;
  localparam int PRESET_PS = 200000;
  localparam int CE_CYC = (CE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SB_CYC = (SB_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REF_CYC = (REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int PRESET_CYC = (PRESET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int COL_W = 5;
  localparam int RAM_A_W = 12;
  localparam int WORD_LSB = 1;
  localparam int ROW_LSB = 13;
  localparam int BOARD_LSB = 15;
  localparam logic [COL_W-1:0] REF_CNT_RST = 5'h00;
  localparam logic [DATA_W-1:0] BDR_RST = 16'h0000;

  typedef enum logic [2:0]
  {
    DRC_IDLE = 3'b000,
    DRC_CE = 3'b001,
    DRC_SLAVE_SYNC = 3'b011,
    DRC_REF = 3'b010,
    DRC_SB = 3'b110
  } drc_state_t;

  // host bus request as seen on the receivers
  typedef struct packed
  {
    logic master_sync;
    logic bus_ctl_first;
    logic bus_ctl_second;
    logic [ADDR_W-1:0] addr;
  } drc_bus_req_t;

  // ram array control bundle
  typedef struct packed
  {
    logic [3:0] row_cs;
    logic [3:0] cycle_clk;
    logic [1:0] write_sel_n;
    logic input_inhibit;
    logic [RAM_A_W-1:0] addr;
  } drc_ram_ctl_t;
endpackage : drc_pkg

// ===== verilog/drc_ctrl.sv
// Purpose: dynamic ram board controller between host bus and ram array
// Assumes: bus inputs synchronous to i_clk; ram polarity handled inside rams
// Notes: one ram cycle per host cycle; refresh stolen between host cycles
`timescale 1ns/1ps
module drc_ctrl
  import drc_pkg::*;
#(
  parameter int REF_CYCLES = REF_CYC
)
(
  input wire logic i_clk,                        // 50 MHz clock
  input wire logic i_sys_rst,                    // sync reset, active high
  input wire drc_bus_req_t i_bus,                // host address and control
  input wire logic [DATA_W-1:0] i_bus_data,      // bus data receivers
  input wire logic [2:0] i_board_jumper,         // board number jumper
  input wire logic [DATA_W-1:0] i_ram_dout,      // ram data outputs
  input wire logic i_preset_test,                // test request for preset pulse
  output logic [DATA_W-1:0] o_bus_data,          // bus data driver value
  output logic [DATA_W-1:0] o_bus_data_oe_n,     // low while driving
  output logic o_slave_sync,                     // slave sync to host
  output logic o_board_select,                   // board select active
  output drc_ram_ctl_t o_ram,                    // ram control bundle
  output logic [DATA_W-1:0] o_ram_din,           // ram input data
  output logic o_ram_preset                      // polarity preset pulse
);

  ////////////////////////////////////////////////////////////////////////
  // decode functions

  // one-hot of a two-bit field
  function automatic logic [3:0] drc_onehot(input logic [1:0] sel);
    drc_onehot = 4'h1 << sel;
  endfunction : drc_onehot

  ////////////////////////////////////////////////////////////////////////
  // state

  drc_state_t state_r, state_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [$clog2(REF_CYCLES+1)-1:0] ref_tmr_r, ref_tmr_nxt;
  logic ref_pend_r, ref_pend_nxt;
  logic [COL_W-1:0] ref_col_r, ref_col_nxt;
  logic [DATA_W-1:0] bdr_r, bdr_nxt;
  logic rd_r, rd_nxt;
  logic [1:0] wr_grp_r, wr_grp_nxt;
  logic [1:0] row_r, row_nxt;
  logic [RAM_A_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] din_r, din_nxt;
  logic drive_r, drive_nxt;
  logic [3:0] pre_cnt_r, pre_cnt_nxt;
  logic pre_req_d_r, pre_req_d_nxt;
  logic board_hit;
  logic host_req;

  // board hit: jumper compare on top address bits
  assign board_hit = (i_bus.addr[BOARD_LSB +: 3] == i_board_jumper);
  assign host_req = i_bus.master_sync & board_hit;

  ////////////////////////////////////////////////////////////////////////
  // main sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ref_tmr_nxt = ref_tmr_r;
    ref_pend_nxt = ref_pend_r;
    ref_col_nxt = ref_col_r;
    bdr_nxt = bdr_r;
    rd_nxt = rd_r;
    wr_grp_nxt = wr_grp_r;
    row_nxt = row_r;
    addr_nxt = addr_r;
    din_nxt = din_r;
    drive_nxt = drive_r;
    // refresh timebase; one stolen cycle per period, never a burst
    if (ref_tmr_r == '0)
    begin
      ref_tmr_nxt = ($bits(ref_tmr_r))'(REF_CYCLES - 1);
      ref_pend_nxt = 1'b1;
    end
    else
    begin
      ref_tmr_nxt = ref_tmr_r - 1'b1;
    end
    case (state_r)
      DRC_IDLE:
      begin
        drive_nxt = 1'b0;
        // refresh wins only between host cycles; a host cycle is never cut
        if (ref_pend_r)
        begin
          state_nxt = DRC_REF;
          cnt_nxt = 9'(CE_CYC);
          addr_nxt = {7'h00, ref_col_r};
          ref_pend_nxt = (ref_tmr_r == '0);
        end
        else if (host_req)
        begin
          state_nxt = DRC_CE;
          cnt_nxt = 9'(CE_CYC);
          addr_nxt = i_bus.addr[WORD_LSB +: RAM_A_W];
          row_nxt = i_bus.addr[ROW_LSB +: 2];
          din_nxt = i_bus_data;
          // decode control pair and byte select
          if (!i_bus.bus_ctl_second)
          begin
            rd_nxt = 1'b1;
            wr_grp_nxt = 2'b00;
          end
          else if (!i_bus.bus_ctl_first)
          begin
            rd_nxt = 1'b0;
            wr_grp_nxt = 2'b11;
          end
          else
          begin
            rd_nxt = 1'b0;
            wr_grp_nxt = i_bus.addr[0] ? 2'b10 : 2'b01;
          end
        end
      end
      DRC_CE:
      begin
        drive_nxt = rd_r;
        if (cnt_r == 9'h001)
        begin
          // trailing edge: capture read data, raise slave sync
          state_nxt = DRC_SLAVE_SYNC;
          if (rd_r)
          begin
            bdr_nxt = i_ram_dout;
          end
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      DRC_SLAVE_SYNC:
      begin
        // data register keeps the bus until master lets go
        if (!i_bus.master_sync)
        begin
          state_nxt = DRC_IDLE;
          drive_nxt = 1'b0;
        end
      end
      DRC_REF:
      begin
        if (cnt_r == 9'h001)
        begin
          state_nxt = DRC_SB;
          cnt_nxt = 9'(SB_CYC);
          ref_col_nxt = ref_col_r + 1'b1;
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      DRC_SB:
      begin
        // standby time after refresh keeps host out
        if (cnt_r == 9'h001)
        begin
          state_nxt = DRC_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default:
      begin
        state_nxt = DRC_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= DRC_IDLE;
      cnt_r <= 9'h000;
      ref_tmr_r <= '0;
      ref_pend_r <= 1'b0;
      ref_col_r <= REF_CNT_RST;
      bdr_r <= BDR_RST;
      rd_r <= 1'b1;
      wr_grp_r <= 2'b00;
      row_r <= 2'b00;
      addr_r <= '0;
      din_r <= 16'h0000;
      drive_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ref_tmr_r <= ref_tmr_nxt;
      ref_pend_r <= ref_pend_nxt;
      ref_col_r <= ref_col_nxt;
      bdr_r <= bdr_nxt;
      rd_r <= rd_nxt;
      wr_grp_r <= wr_grp_nxt;
      row_r <= row_nxt;
      addr_r <= addr_nxt;
      din_r <= din_nxt;
      drive_r <= drive_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // preset pulse: rising request gives a fixed 200 ns pulse
  always_comb
  begin
    pre_req_d_nxt = i_preset_test;
    pre_cnt_nxt = pre_cnt_r;
    if (i_preset_test && !pre_req_d_r && pre_cnt_r == 4'h0)
    begin
      pre_cnt_nxt = 4'(PRESET_CYC);
    end
    else if (pre_cnt_r != 4'h0)
    begin
      pre_cnt_nxt = pre_cnt_r - 1'b1;
    end
  end

  // preset registers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pre_cnt_r <= 4'h0;
      pre_req_d_r <= 1'b0;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_nxt;
      pre_req_d_r <= pre_req_d_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; cycle clock high only in ce or refresh states, low is precharge
  logic in_ce, in_ref;
  assign in_ce = (state_r == DRC_CE);
  assign in_ref = (state_r == DRC_REF);
  assign o_ram.cycle_clk = in_ref ? 4'hF : (in_ce ? drc_onehot(row_r) : 4'h0);
  assign o_ram.row_cs = in_ce ? drc_onehot(row_r) : 4'h0;
  // reads keep both groups high; refresh writes all with inhibit
  assign o_ram.write_sel_n = in_ref ? 2'b00 : (in_ce ? ~wr_grp_r : 2'b11);
  assign o_ram.input_inhibit = in_ref;
  assign o_ram.addr = addr_r;
  assign o_ram_din = din_r;
  assign o_ram_preset = (pre_cnt_r != 4'h0);
  assign o_bus_data = bdr_r;
  assign o_bus_data_oe_n = {DATA_W{~drive_r}};
  assign o_slave_sync = (state_r == DRC_SLAVE_SYNC);
  assign o_board_select = (state_r == DRC_CE) || (state_r == DRC_SLAVE_SYNC);

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ce_start;
    $rose(in_ce);
  endsequence
  sequence s_ce_hold;
    in_ce [*8];
  endsequence

  a_ce_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_ce_start |-> s_ce_hold ##1 s_ce_hold ##1 in_ce) else $error("cycle clock shorter than minimum");
  a_read_wsel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (in_ce && rd_r) |-> o_ram.write_sel_n == 2'b11) else $error("write select low in read");
  a_ref_cs_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    in_ref |-> (o_ram.row_cs == 4'h0 && !o_board_select)) else $error("chip select during refresh");
  a_sb_gap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(in_ref) |-> !in_ce [*6]) else $error("host cycle inside standby gap");
  a_slave_sync_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_slave_sync && !i_bus.master_sync) |=> !o_slave_sync) else $error("slave sync stuck");
  a_slave_sync_after_ce: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(in_ce) |-> o_slave_sync) else $error("slave sync late");
  a_bdr_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_slave_sync && $past(o_slave_sync)) |-> $stable(bdr_r)) else $error("data register changed");
  a_ref_col_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(in_ref) |-> ref_col_r == $past(ref_col_r) + 5'h01) else $error("refresh column not advanced");
  a_release_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == DRC_IDLE && !$past(o_slave_sync)) |-> &o_bus_data_oe_n) else $error("bus driven idle");
  a_preset_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_ram_preset) |-> o_ram_preset [*8] ##1 o_ram_preset [*2] ##1 !o_ram_preset)
    else $error("preset pulse wrong length");

  // refresh steps: a full cycle clock on every row, then the standby gap
  sequence s_ref_run;
    in_ref [*8] ##1 in_ref [*8] ##1 in_ref;
  endsequence
  sequence s_standby;
    (state_r == DRC_SB) [*6];
  endsequence

  // refresh and its gap are timed like a host cycle so the ram always gets its standby
  a_ref_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(in_ref) |-> s_ref_run ##1 s_standby)
    else $error("refresh or standby wrong length");

  // refresh is a write on all rows with the data inputs held off
  a_ref_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    in_ref |-> (o_ram.write_sel_n == 2'b00 && o_ram.input_inhibit && o_ram.cycle_clk == 4'hF))
    else $error("refresh not an inhibited write");

  // the rams latch the address at the rise; moving it later would not matter, but it hides faults
  a_addr_stable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((in_ce && $past(in_ce)) || (in_ref && $past(in_ref))) |-> $stable(o_ram.addr))
    else $error("address moved inside a cycle");

  // only the addressed row is clocked and selected in a host cycle
  a_row_onehot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    in_ce |-> ($onehot(o_ram.cycle_clk) && o_ram.row_cs == o_ram.cycle_clk))
    else $error("row select not one-hot");

  // a host write lowers at least one group
  a_write_grp: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (in_ce && !rd_r) |-> (o_ram.write_sel_n != 2'b11))
    else $error("write cycle with no group selected");

  // outside ce and refresh the rams sit in precharge
  a_precharge_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!in_ce && !in_ref) |-> o_ram.cycle_clk == 4'h0)
    else $error("cycle clock high in standby");

  // the data drivers only run while a read answer is on its way or standing
  a_drive_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(&o_bus_data_oe_n) |-> (rd_r && (in_ce || o_slave_sync)))
    else $error("bus driven outside a read");

  // host select stays off in the standby gap
  a_bsel_block: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == DRC_SB) |-> !o_board_select)
    else $error("board select in standby gap");

  // another board's address never starts a cycle here
  a_foreign_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == DRC_IDLE && !ref_pend_r && i_bus.master_sync && !board_hit) |=> !in_ce)
    else $error("cycle started for another board");

  // the data register takes what the ram showed on the last ce cycle
  a_bdr_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($rose(o_slave_sync) && rd_r) |-> bdr_r == $past(i_ram_dout))
    else $error("read data not captured");

endmodule : drc_ctrl

// ===== test/drc_ram_model.sv
// Purpose: behavioural ram array seen by the controller, four rows of 4096 x 16
// Assumes: cycle clock one-hot per row in host cycles, all rows in refresh
// Notes: stores true data; the polarity cells stay hidden inside the array
`timescale 1ns/1ps
module drc_ram_model
  import drc_pkg::*;
(
  input wire logic i_clk,                     // system clock
  input wire drc_ram_ctl_t i_ram,             // ram control bundle
  input wire logic [DATA_W-1:0] i_din,        // ram input data
  output logic [DATA_W-1:0] o_dout,           // ram output data
  output logic [7:0] o_ref_count = 8'h00,     // refresh cycles seen
  output logic [COL_W-1:0] o_last_col,        // column of last refresh
  output logic [1:0] o_last_wsel,             // write select of last cycle
  output logic o_last_inh,                    // inhibit of last cycle
  output logic [7:0] o_ce_len                 // length of last cycle clock
);
  logic [DATA_W-1:0] mem [0:16383];
  logic [3:0] ck_q = 4'h0;
  logic [13:0] key;
  logic [DATA_W-1:0] din_q;
  logic [1:0] wsel_q;
  logic inh_q;

  function automatic logic [1:0] row_of(input logic [3:0] c);
    return c[3] ? 2'h3 : (c[2] ? 2'h2 : (c[1] ? 2'h1 : 2'h0));
  endfunction : row_of

  ////////////////////////////////////////
  // one cycle per cycle clock pulse; released output toggles every clock
  always @(posedge i_clk)
  begin : cyc
    logic [13:0] k;
    logic [DATA_W-1:0] w;
    ck_q <= i_ram.cycle_clk;
    if (i_ram.cycle_clk != 4'h0)
    begin
      k = (ck_q == 4'h0) ? {row_of(i_ram.cycle_clk), i_ram.addr} : key;
      key <= k;
      o_ce_len <= (ck_q == 4'h0) ? 8'h01 : o_ce_len + 8'h01;
      o_dout <= mem[k];
      din_q <= i_din;
      wsel_q <= i_ram.write_sel_n;
      inh_q <= i_ram.input_inhibit;
    end
    else
    begin
      o_dout <= ~o_dout;
      if (ck_q != 4'h0)
      begin
        o_last_wsel <= wsel_q;
        o_last_inh <= inh_q;
        if (ck_q == 4'hF)
        begin
          o_ref_count <= o_ref_count + 8'h01;
          o_last_col <= key[COL_W-1:0];
        end
        // inhibit turns a write into a pure refresh of the column
        if (!inh_q && wsel_q != 2'h3)
        begin
          w = mem[key];
          if (!wsel_q[0])
            w[7:0] = din_q[7:0];
          if (!wsel_q[1])
            w[15:8] = din_q[15:8];
          mem[key] = w;
        end
      end
    end
  end
endmodule : drc_ram_model

// ===== test/drc_ctrl_tb.sv
// Purpose: self-checking bench for the ram board controller
// Assumes: refresh period shortened to 200 cycles
// Notes: host bus driven at falling edges; board number 5
`timescale 1ns/1ps
module drc_ctrl_tb
  import drc_pkg::*;
;
  logic i_clk, i_sys_rst, i_preset_test;
  drc_bus_req_t i_bus;
  logic [DATA_W-1:0] i_bus_data, ram_dout, o_bus_data, o_bus_data_oe_n, o_ram_din;
  logic [2:0] i_board_jumper;
  logic o_slave_sync, o_board_select, o_ram_preset, last_inh, in_gap;
  drc_ram_ctl_t o_ram;
  logic [7:0] ref_count, ce_len, since = 8'hFF;
  logic [COL_W-1:0] last_col;
  logic [1:0] last_wsel;
  logic [DATA_W-1:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;

  drc_ctrl #(.REF_CYCLES(200)) u_drc_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
    .i_bus_data(i_bus_data), .i_board_jumper(i_board_jumper), .i_ram_dout(ram_dout),
    .i_preset_test(i_preset_test), .o_bus_data(o_bus_data), .o_bus_data_oe_n(o_bus_data_oe_n),
    .o_slave_sync(o_slave_sync), .o_board_select(o_board_select), .o_ram(o_ram),
    .o_ram_din(o_ram_din), .o_ram_preset(o_ram_preset));
  drc_ram_model u_drc_ram_model (.i_clk(i_clk), .i_ram(o_ram), .i_din(o_ram_din), .o_dout(ram_dout),
    .o_ref_count(ref_count), .o_last_col(last_col), .o_last_wsel(last_wsel), .o_last_inh(last_inh),
    .o_ce_len(ce_len));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////
  // one whole host cycle; holds master sync a while to prove data is kept
  task automatic bus_op(input logic f, input logic s, input logic [17:0] a, input logic [15:0] wd);
    int n;
    logic [1:0] ew;
    logic [3:0] cs;
    n = 0;
    cs = 4'h0;
    ew = !s ? 2'h3 : (!f ? 2'h0 : (a[0] ? 2'h1 : 2'h2));
    @(negedge i_clk);
    i_bus = '{master_sync: 1'b1, bus_ctl_first: f, bus_ctl_second: s, addr: a};
    i_bus_data = wd;
    while (o_slave_sync !== 1'b1 && n < 100)
    begin
      @(negedge i_clk);
      cs = cs | o_ram.row_cs;
      n++;
    end
    check("ssync", {15'h0000, o_slave_sync}, 16'h0001);
    check("row_cs", {12'h000, cs}, {12'h000, 4'h1 << a[14:13]});
    // the model logs a cycle only once the cycle clock has dropped
    repeat (3) @(negedge i_clk);
    check("ce_len", {15'h0000, ce_len >= 8'(CE_CYC)}, 16'h0001);
    check("wsel", {14'h0000, last_wsel}, {14'h0000, ew});
    rd = o_bus_data;
    check("ce_end", {12'h000, o_ram.cycle_clk}, 16'h0000);
    check("oe_hold", o_bus_data_oe_n, s ? 16'hFFFF : 16'h0000);
    i_bus.master_sync = 1'b0;
    repeat (2) @(negedge i_clk);
    check("ssync_clr", {15'h0000, o_slave_sync}, 16'h0000);
    check("oe_rel", o_bus_data_oe_n, 16'hFFFF);
  endtask : bus_op

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // watchdog sized well past the expected run of under a thousand cycles
  initial
  begin
    #(20000 * 20);
    n_mismatch++;
    finish_test();
  end

  // host select must stay off in refresh and in the standby gap after it
  // cycles since the last refresh clock cycle; saturates so it never wraps back into the gap
  always @(posedge i_clk)
  begin
    since <= (o_ram.cycle_clk == 4'hF) ? 8'h00 : ((since == 8'hFF) ? since : since + 8'h01);
  end
  assign in_gap = (o_ram.cycle_clk == 4'hF) || (since < 8'(SB_CYC));
  always @(negedge i_clk)
    if (!i_sys_rst)
      check("bsel_gap", {15'h0000, o_board_select & in_gap}, 16'h0000);

  initial
  begin : main
    int n;
    i_sys_rst = 1'b1;
    i_bus = '0;
    i_bus_data = 16'h0000;
    i_preset_test = 1'b0;
    i_board_jumper = 3'h5;
    repeat (5) @(negedge i_clk);
    i_sys_rst = 1'b0;
    // refreshes run before any stored data is relied on
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      while (ref_count !== 8'(k + 1) && n < 400)
      begin
        @(negedge i_clk);
        n++;
      end
      check("ref_col", {11'h000, last_col}, 16'(k));
      check("ref_mode", {13'h0000, last_wsel, last_inh}, 16'h0001);
    end
    // same word address in each of the four rows
    for (int i = 0; i < 4; i++)
      bus_op(1'b0, 1'b1, {3'h5, 2'(i), 12'hA5C, 1'b0}, {4{4'(i)}} ^ 16'hA5C3);
    for (int i = 0; i < 4; i++)
    begin
      bus_op(1'b0, 1'b0, {3'h5, 2'(i), 12'hA5C, 1'b0}, 16'h0000);
      check("row_data", rd, {4{4'(i)}} ^ 16'hA5C3);
    end
    // byte lanes, then a neighbouring word that must not alias
    bus_op(1'b0, 1'b1, 18'h2A002, 16'h0000);
    bus_op(1'b1, 1'b1, 18'h2A002, 16'h12AB);
    bus_op(1'b1, 1'b1, 18'h2A003, 16'hCD34);
    bus_op(1'b0, 1'b1, 18'h2A004, 16'h5555);
    bus_op(1'b0, 1'b0, 18'h2A003, 16'h0000);
    check("byte_data", rd, 16'hCDAB);
    // another board's address gets no answer
    @(negedge i_clk);
    i_bus = '{master_sync: 1'b1, bus_ctl_first: 1'b0, bus_ctl_second: 1'b0, addr: 18'h10100};
    n = 0;
    repeat (40)
    begin
      @(negedge i_clk);
      if (o_slave_sync === 1'b1 || o_board_select === 1'b1)
        n++;
    end
    check("foreign", 16'(n), 16'h0000);
    i_bus.master_sync = 1'b0;
    // preset request gives one pulse of fixed length
    @(negedge i_clk);
    i_preset_test = 1'b1;
    n = 0;
    repeat (20)
    begin
      @(negedge i_clk);
      i_preset_test = 1'b0;
      if (o_ram_preset === 1'b1)
        n++;
    end
    check("preset_len", 16'(n), 16'(PRESET_CYC));
    finish_test();
  end
endmodule : drc_ctrl_tb
